//--- core/rrse_pkg.sv
// package: opcodes, field layout, reset values and timing for the exec block
package rrse_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned ADDR_W        = 7;
  localparam int unsigned PC_W          = 13;
  localparam int unsigned STACK_DEPTH   = 8;
  localparam int unsigned WDT_W         = 8;
  localparam int unsigned PRE_W         = 8;
  // 14-bit instruction encodings
  localparam logic [13:0] OPC_RETURN    = 14'h0008;
  localparam logic [13:0] OPC_SLEEP     = 14'h0063;
  localparam logic [5:0]  OPC_RLF_HI    = 6'h0D;
  localparam logic [5:0]  OPC_RRF_HI    = 6'h0C;
  // instruction field positions
  localparam int unsigned OP_HI_POS     = 8;
  localparam int unsigned DEST_POS      = 7;
  // destination select values
  localparam logic        DEST_ACC      = 1'b0;
  localparam logic        DEST_FILE     = 1'b1;
  // reset values
  localparam logic [7:0]  WDT_CLEAR     = 8'h00;
  localparam logic [7:0]  PRE_CLEAR     = 8'h00;
  localparam logic        PD_RESET      = 1'b1;
  localparam logic        TO_RESET      = 1'b1;
  localparam logic [12:0] PC_RESET      = 13'h0000;
  // cycle counts
  localparam int unsigned RETURN_CYCLES = 2;
  localparam int unsigned ROT_CYCLES    = 1;

  typedef enum logic [3:0] {
    RRSE_IDLE   = 4'b0001,
    RRSE_RET2   = 4'b0010,
    RRSE_SLEEP  = 4'b0100,
    RRSE_WAKE   = 4'b1000
  } rrse_state_t;
endpackage : rrse_pkg

//--- core/rrse_rotator.sv
// rotate-through-carry datapath, one instance per direction
`timescale 1ns/1ps
module rrse_rotator
  import rrse_pkg::*;
#(
  parameter int unsigned W    = 8,
  parameter bit          LEFT = 1'b1
) (
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_carry,
  output logic      [W-1:0] o_data,
  output logic              o_carry
);
  generate
    if (LEFT)
    begin : g_left
      assign o_data  = {i_data[W-2:0], i_carry};
      assign o_carry = i_data[W-1];
    end
    else
    begin : g_right
      assign o_data  = {i_carry, i_data[W-1:1]};
      assign o_carry = i_data[0];
    end
  endgenerate
endmodule : rrse_rotator

//--- core/rrse_exec.sv
// execution unit for return, rotate-through-carry and power-down instructions
// Functional notes
// [RQ1] return pops the call stack into the program counter and takes two cycles.
// [RQ2] rotate left moves msb into carry and old carry into bit zero of the addressed register.
// [RQ3] rotate left with destination 0 writes the accumulator, with 1 the source register.
// [RQ4] rotate right moves lsb into carry and old carry into the msb of the addressed register.
// [RQ5] rotate right with destination 0 writes the accumulator, with 1 the source register.
// [RQ6] power-down clears the power-down flag and sets the time-out flag.
// [RQ7] power-down clears the watchdog counter and its prescaler.
// [RQ8] after power-down the core sleeps with the oscillator stopped until a wake event.
// [RQ9] rotates take one cycle and change only carry; return and power-down keep arithmetic flags.
`timescale 1ns/1ps
module rrse_exec
  import rrse_pkg::*;
#(
  parameter int unsigned DEPTH = STACK_DEPTH
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_instr_valid,
  input  wire logic [13:0]       i_instr,
  input  wire logic [DATA_W-1:0] i_file_rdata,
  input  wire logic              i_carry,
  input  wire logic [PC_W-1:0]   i_pc_push_addr,
  input  wire logic              i_push,
  input  wire logic              i_wake,
  output logic                   o_busy,
  output logic [DATA_W-1:0]      o_acc_wdata,
  output logic                   o_acc_we,
  output logic [ADDR_W-1:0]      o_file_addr,
  output logic [DATA_W-1:0]      o_file_wdata,
  output logic                   o_file_we,
  output logic                   o_carry,
  output logic                   o_carry_we,
  output logic [PC_W-1:0]        o_pc,
  output logic                   o_pc_load,
  output logic                   o_powerdown_status_flag_n,
  output logic                   o_timeout_status_flag_n,
  output logic [WDT_W-1:0]       o_watchdog_counter,
  output logic [PRE_W-1:0]       o_wdt_prescaler,
  output logic                   o_osc_run
);
  localparam int unsigned SP_W = $clog2(DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // decode
  rrse_state_t          state_r;
  logic [PC_W-1:0]      stack_r [DEPTH];
  logic [SP_W-1:0]      sp_r;
  logic                 accept;
  logic                 is_ret;
  logic                 is_slp;
  logic                 is_rlf;
  logic                 is_rrf;
  logic [DATA_W-1:0]    rl_data;
  logic [DATA_W-1:0]    rr_data;
  logic                 rl_c;
  logic                 rr_c;
  logic [SP_W-1:0]      sp_pop;

  assign accept = i_instr_valid && (state_r == RRSE_IDLE);
  assign is_ret = accept && (i_instr == OPC_RETURN);
  assign is_slp = accept && (i_instr == OPC_SLEEP);
  assign is_rlf = accept && (i_instr[13:OP_HI_POS] == OPC_RLF_HI);
  assign is_rrf = accept && (i_instr[13:OP_HI_POS] == OPC_RRF_HI);
  assign sp_pop = sp_r - SP_W'(1);

  rrse_rotator #(.W(DATA_W), .LEFT(1'b1)) u_rol (
    .i_data  (i_file_rdata),
    .i_carry (i_carry),
    .o_data  (rl_data),
    .o_carry (rl_c)
  );

  rrse_rotator #(.W(DATA_W), .LEFT(1'b0)) u_ror (
    .i_data  (i_file_rdata),
    .i_carry (i_carry),
    .o_data  (rr_data),
    .o_carry (rr_c)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      state_r <= RRSE_IDLE;
    else
    begin
      case (state_r)
        RRSE_IDLE:
        begin
          if (is_ret)
            state_r <= RRSE_RET2; // [RQ1]
          else if (is_slp)
            state_r <= RRSE_SLEEP; // [RQ8]
        end
        RRSE_RET2:  state_r <= RRSE_IDLE;
        RRSE_SLEEP:
        begin
          if (i_wake)
            state_r <= RRSE_WAKE;
        end
        RRSE_WAKE:  state_r <= RRSE_IDLE;
        default:    state_r <= RRSE_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_busy    <= 1'b0;
      o_osc_run <= 1'b1;
    end
    else
    begin
      o_busy    <= is_ret || is_slp || (state_r == RRSE_SLEEP && !i_wake);
      o_osc_run <= !(is_slp || (state_r == RRSE_SLEEP && !i_wake)); // [RQ8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // call stack
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sp_r      <= '0;
      o_pc      <= PC_RESET;
      o_pc_load <= 1'b0;
    end
    else
    begin
      o_pc_load <= is_ret; // [RQ1]
      if (is_ret)
      begin
        o_pc <= stack_r[sp_pop]; // [RQ1]
        sp_r <= sp_pop;
      end
      else if (i_push && state_r == RRSE_IDLE)
      begin
        stack_r[sp_r] <= i_pc_push_addr;
        sp_r          <= sp_r + SP_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rotate datapath
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_acc_wdata  <= '0;
      o_acc_we     <= 1'b0;
      o_file_addr  <= '0;
      o_file_wdata <= '0;
      o_file_we    <= 1'b0;
      o_carry      <= 1'b0;
      o_carry_we   <= 1'b0;
    end
    else
    begin
      o_carry_we  <= is_rlf || is_rrf; // [RQ9]
      o_carry     <= is_rlf ? rl_c : rr_c; // [RQ2] [RQ4]
      o_acc_we    <= (is_rlf || is_rrf) && i_instr[DEST_POS] == DEST_ACC; // [RQ3] [RQ5]
      o_file_we   <= (is_rlf || is_rrf) && i_instr[DEST_POS] == DEST_FILE; // [RQ3] [RQ5]
      o_file_addr <= i_instr[ADDR_W-1:0];
      o_acc_wdata <= is_rlf ? rl_data : rr_data;
      o_file_wdata <= is_rlf ? rl_data : rr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power status and watchdog
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_powerdown_status_flag_n <= PD_RESET;
      o_timeout_status_flag_n   <= TO_RESET;
      o_watchdog_counter        <= WDT_CLEAR;
      o_wdt_prescaler           <= PRE_CLEAR;
    end
    else if (is_slp)
    begin
      o_powerdown_status_flag_n <= 1'b0; // [RQ6]
      o_timeout_status_flag_n   <= 1'b1; // [RQ6]
      o_watchdog_counter        <= WDT_CLEAR; // [RQ7]
      o_wdt_prescaler           <= PRE_CLEAR; // [RQ7]
    end
    else if (o_osc_run)
    begin
      o_wdt_prescaler <= o_wdt_prescaler + PRE_W'(1);
      if (&o_wdt_prescaler)
        o_watchdog_counter <= o_watchdog_counter + WDT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  ret_two_cyc_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ1]
    is_ret |=> state_r == RRSE_RET2 ##1 state_r == RRSE_IDLE)
    else $error("return not two cycles");
  ret_pc_load_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ1]
    is_ret |=> o_pc_load && o_pc == $past(stack_r[sp_pop]))
    else $error("return pc wrong");
  rol_value_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ2]
    is_rlf |=> o_carry == $past(i_file_rdata[DATA_W-1])
      && o_acc_wdata == {$past(i_file_rdata[DATA_W-2:0]), $past(i_carry)})
    else $error("rotate left wrong");
  rol_dest_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ3]
    is_rlf |=> o_file_we == $past(i_instr[DEST_POS]) && o_acc_we != o_file_we)
    else $error("rotate left destination wrong");
  ror_value_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ4]
    is_rrf |=> o_carry == $past(i_file_rdata[0])
      && o_file_wdata == {$past(i_carry), $past(i_file_rdata[DATA_W-1:1])})
    else $error("rotate right wrong");
  ror_dest_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ5]
    is_rrf |=> o_acc_we == !$past(i_instr[DEST_POS]) && o_acc_we != o_file_we)
    else $error("rotate right destination wrong");
  sleep_flags_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ6]
    is_slp |=> !o_powerdown_status_flag_n && o_timeout_status_flag_n)
    else $error("power flags wrong");
  sleep_wdt_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ7]
    is_slp |=> o_watchdog_counter == WDT_CLEAR && o_wdt_prescaler == PRE_CLEAR)
    else $error("watchdog not cleared");
  sleep_halt_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ8]
    is_slp |=> !o_osc_run && o_busy ##1 $stable(o_watchdog_counter) && $stable(o_wdt_prescaler))
    else $error("oscillator not halted");
  rot_carry_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RQ9]
    (is_ret || is_slp) |=> !o_carry_we ##1 !o_carry_we)
    else $error("carry touched by non-rotate");
endmodule : rrse_exec

//--- sim/rrse_exec_tb_top.sv
// self-checking testbench for the return, rotate and power-down execution unit
`timescale 1ns/1ps
module rrse_exec_tb_top
  import rrse_pkg::*;
;
  logic              i_clk;
  logic              i_rst;
  logic              i_instr_valid;
  logic [13:0]       i_instr;
  logic [DATA_W-1:0] i_file_rdata;
  logic              i_carry;
  logic [PC_W-1:0]   i_pc_push_addr;
  logic              i_push;
  logic              i_wake;
  logic              o_busy, o_acc_we, o_file_we, o_carry, o_carry_we, o_pc_load, o_osc_run;
  logic [DATA_W-1:0] o_acc_wdata, o_file_wdata;
  logic [ADDR_W-1:0] o_file_addr;
  logic [PC_W-1:0]   o_pc;
  logic              o_powerdown_status_flag_n, o_timeout_status_flag_n;
  logic [WDT_W-1:0]  o_watchdog_counter;
  logic [PRE_W-1:0]  o_wdt_prescaler;
  int                err_total;
  int                samples_checked;
  logic [7:0]        dat_tbl [4] = '{8'hE6, 8'h81, 8'h5A, 8'h01};

  rrse_exec i_rrse_exec (.i_clk(i_clk), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_file_rdata(i_file_rdata), .i_carry(i_carry),
    .i_pc_push_addr(i_pc_push_addr), .i_push(i_push), .i_wake(i_wake), .o_busy(o_busy),
    .o_acc_wdata(o_acc_wdata), .o_acc_we(o_acc_we), .o_file_addr(o_file_addr),
    .o_file_wdata(o_file_wdata), .o_file_we(o_file_we), .o_carry(o_carry),
    .o_carry_we(o_carry_we), .o_pc(o_pc), .o_pc_load(o_pc_load),
    .o_powerdown_status_flag_n(o_powerdown_status_flag_n),
    .o_timeout_status_flag_n(o_timeout_status_flag_n),
    .o_watchdog_counter(o_watchdog_counter), .o_wdt_prescaler(o_wdt_prescaler),
    .o_osc_run(o_osc_run));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  // present one instruction; returns just after the edge whose results it answers
  task automatic send(input logic [13:0] ins, input logic [7:0] d, input logic c);
    @(posedge i_clk);
    i_instr_valid <= 1'b1;
    i_instr       <= ins;
    i_file_rdata  <= d;
    i_carry       <= c;
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    #1;
  endtask : send

  task automatic rot(input bit left, input logic dest, input logic [6:0] a,
                     input logic [7:0] d, input logic c);
    logic [7:0] ev;
    logic       ec;
    ev = left ? {d[6:0], c} : {c, d[7:1]};
    ec = left ? d[7] : d[0];
    send({left ? OPC_RLF_HI : OPC_RRF_HI, dest, a}, d, c);
    chk("carry_we", 16'h1, o_carry_we);
    chk("carry", ec, o_carry);
    chk("acc_we", dest == DEST_ACC, o_acc_we);
    chk("file_we", dest == DEST_FILE, o_file_we);
    if (dest == DEST_ACC)
      chk("acc_wdata", ev, o_acc_wdata);
    else
    begin
      chk("file_wdata", ev, o_file_wdata);
      chk("file_addr", a, o_file_addr);
    end
  endtask : rot

  task automatic push(input logic [PC_W-1:0] a);
    @(posedge i_clk);
    i_push         <= 1'b1;
    i_pc_push_addr <= a;
    @(posedge i_clk);
    i_push         <= 1'b0;
  endtask : push

  task automatic ret(input logic [PC_W-1:0] exp);
    send(OPC_RETURN, 8'h00, 1'b1);
    chk("pc_load", 16'h1, o_pc_load);
    chk("pc", exp, o_pc);
    chk("busy ret", 16'h1, o_busy);
    chk("carry_we ret", 16'h0, o_carry_we);
    @(posedge i_clk);
    #1;
    chk("pc_load low", 16'h0, o_pc_load);
  endtask : ret

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_total = 0;
    samples_checked = 0;
    i_rst = 1'b1;
    i_instr_valid = 1'b0;
    i_instr = 14'h0000;
    i_file_rdata = 8'h00;
    i_carry = 1'b0;
    i_pc_push_addr = 13'h0000;
    i_push = 1'b0;
    i_wake = 1'b0;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    chk("pd_n reset", PD_RESET, o_powerdown_status_flag_n);
    chk("osc reset", 16'h1, o_osc_run);
    for (int i = 0; i < 16; i++)
      rot(i[0], i[1], i[3] ? 7'h7F : 7'h00, dat_tbl[i[3:2]], i[2]);
    push(13'h0ABC);
    push(13'h1123);
    ret(13'h1123);
    rot(1'b0, DEST_FILE, 7'h15, 8'h3C, 1'b1);
    ret(13'h0ABC);
    // let the watchdog count off zero so the clear on power-down is visible
    repeat (300) @(posedge i_clk);
    send(OPC_SLEEP, 8'h00, 1'b0);
    chk("pd_n", 16'h0, o_powerdown_status_flag_n);
    chk("to_n", 16'h1, o_timeout_status_flag_n);
    chk("wdt", WDT_CLEAR, o_watchdog_counter);
    chk("prescaler", PRE_CLEAR, o_wdt_prescaler);
    chk("osc sleep", 16'h0, o_osc_run);
    chk("carry_we sleep", 16'h0, o_carry_we);
    send({OPC_RLF_HI, DEST_ACC, 7'h01}, 8'hFF, 1'b1);
    chk("acc_we asleep", 16'h0, o_acc_we);
    chk("busy asleep", 16'h1, o_busy);
    repeat (20) @(posedge i_clk);
    #1;
    chk("osc held", 16'h0, o_osc_run);
    @(posedge i_clk);
    i_wake <= 1'b1;
    @(posedge i_clk);
    #1;
    chk("osc wake", 16'h1, o_osc_run);
    chk("busy wake", 16'h0, o_busy);
    @(posedge i_clk);
    i_wake <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk("pd_n kept", 16'h0, o_powerdown_status_flag_n);
    rot(1'b1, DEST_ACC, 7'h22, 8'hE6, 1'b0);
    // mid-run reset brings the power-down flag back to its reset level
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    chk("pd_n rearm", PD_RESET, o_powerdown_status_flag_n);
    chk("pc rearm", PC_RESET, o_pc);
    close_out();
  end

  initial
  begin
    repeat (5000) @(posedge i_clk);
    err_total++;
    $display("mismatch watchdog expected done seen hang");
    close_out();
  end
endmodule : rrse_exec_tb_top
